/* logic/rbm_regs.svh */
// constants of the reset boot mode selector
`ifndef RBM_REGS_SVH
`define RBM_REGS_SVH
`define RBM_PC_START     16'h0000
`define RBM_SETTLE_CYC   8
`define RBM_SETTLE_MIN   5
`define RBM_SETTLE_MAX   256
`define RBM_REG_ON_RST   1'b1
`define RBM_BYPASS_OFF   1'b0
`endif

/* logic/rbm_pkg.sv */
// types of the reset boot mode selector
package rbm_pkg;
   typedef enum logic [1:0] {
      RBM_USER      = 2'b00,
      RBM_BOOTSTRAP = 2'b01,
      RBM_DEBUG     = 2'b10,
      RBM_USER_JTAG = 2'b11
   } rbm_mode_t;

   typedef enum logic {
      RBM_ST_SETTLE = 1'b0,
      RBM_ST_RUN    = 1'b1
   } rbm_fsm_t;

   typedef logic [7:0] rbm_cnt_t;

   typedef struct packed {
      logic boot_control;
      logic test_select;
      logic port0_bit0;
   } rbm_pins_t;

   typedef struct packed {
      rbm_fsm_t  fsm;
      rbm_cnt_t  cnt;
      rbm_pins_t s1;
      rbm_pins_t s2;
      rbm_pins_t s3;
      rbm_pins_t stable;
      rbm_mode_t mode;
      logic      valid;
      logic      refused;
      logic      invalid;
      logic      jtag;
      logic      debug;
      logic      reg_on;
      logic      bypass;
      logic [15:0] pc;
   } rbm_state_t;
endpackage

/* logic/rbm_boot_select.sv */
// reset boot mode selector: strap sampling, mode decode, regulator
`timescale 1ns/1ps
`include "rbm_regs.svh"

module rbm_boot_select #(
   parameter int SETTLE_CYCLES = `RBM_SETTLE_CYC
) (
   input  wire logic            clk_in,
   input  wire logic            resetn_in,
   input  wire logic            boot_control_pin_in,
   input  wire logic            test_select_pin_in,
   input  wire logic            port0_bit0_pin_in,
   input  wire logic            por_req_in,
   input  wire logic            hw_reset_req_in,
   input  wire logic            wakeup_req_in,
   input  wire logic            regulator_off_req_in,
   input  wire logic            flash_protected_in,
   output rbm_pkg::rbm_mode_t   mode_out,
   output logic                 mode_valid_out,
   output logic [15:0]          pc_start_out,
   output logic                 osc_pll_bypass_out,
   output logic                 jtag_enable_out,
   output logic                 debug_enable_out,
   output logic                 debug_refused_out,
   output logic                 boot_invalid_out,
   output logic                 regulator_on_out
);
   localparam rbm_pkg::rbm_cnt_t CNT_LOAD =
      rbm_pkg::rbm_cnt_t'(SETTLE_CYCLES - 1);

   localparam rbm_pkg::rbm_state_t RST = '{
      fsm:     rbm_pkg::RBM_ST_SETTLE,
      cnt:     CNT_LOAD,
      s1:      3'h0,
      s2:      3'h0,
      s3:      3'h0,
      stable:  3'h0,
      mode:    rbm_pkg::RBM_USER,
      valid:   1'b0,
      refused: 1'b0,
      invalid: 1'b0,
      jtag:    1'b0,
      debug:   1'b0,
      reg_on:  `RBM_REG_ON_RST,
      bypass:  `RBM_BYPASS_OFF,
      pc:      `RBM_PC_START
   };

   if (SETTLE_CYCLES < `RBM_SETTLE_MIN ||
       SETTLE_CYCLES > `RBM_SETTLE_MAX) begin : g_chk
      $error("SETTLE_CYCLES out of range");
   end

   rbm_pkg::rbm_state_t q;
   rbm_pkg::rbm_state_t next_q;
   rbm_pkg::rbm_pins_t  pins;
   logic [2:0]          next_stable;
   logic                restart;
   logic                capture;

   assign pins = '{boot_control: boot_control_pin_in,
                   test_select:  test_select_pin_in,
                   port0_bit0:   port0_bit0_pin_in};
   assign restart = por_req_in | hw_reset_req_in;
   assign capture = (q.fsm == rbm_pkg::RBM_ST_SETTLE) &&
                    (q.cnt == 8'h00) && !restart;

   // strap level counts once second and third stages agree
   for (genvar i = 0; i < 3; i++) begin : g_sync
      assign next_stable[i] = (q.s2[i] == q.s3[i]) ? q.s3[i]
                                                   : q.stable[i];
   end

   always_comb begin
      next_q        = q;
      next_q.s1     = pins;
      next_q.s2     = q.s1;
      next_q.s3     = q.s2;
      next_q.stable = next_stable;
      // regulator: wake-up wins over an off request
      if (wakeup_req_in) begin
         next_q.reg_on = 1'b1;
      end else if (regulator_off_req_in) begin
         next_q.reg_on = 1'b0;
      end
      case (q.fsm)
         rbm_pkg::RBM_ST_SETTLE: begin
            if (restart) begin
               next_q.cnt = CNT_LOAD;
            end else if (q.cnt != 8'h00) begin
               next_q.cnt = q.cnt - 8'h01;
            end else begin
               // one capture per reset, held afterwards
               next_q.fsm     = rbm_pkg::RBM_ST_RUN;
               next_q.valid   = 1'b1;
               next_q.pc      = `RBM_PC_START;
               next_q.bypass  = `RBM_BYPASS_OFF;
               next_q.refused = 1'b0;
               next_q.invalid = 1'b0;
               next_q.jtag    = 1'b0;
               next_q.debug   = 1'b0;
               if (!q.stable.test_select) begin
                  if (q.stable.boot_control) begin
                     next_q.mode = rbm_pkg::RBM_USER;
                  end else begin
                     next_q.mode = rbm_pkg::RBM_BOOTSTRAP;
                  end
               end else if (q.stable.port0_bit0) begin
                  next_q.mode    = rbm_pkg::RBM_USER;
                  next_q.invalid = 1'b1;
               end else if (q.stable.boot_control) begin
                  next_q.mode = rbm_pkg::RBM_USER_JTAG;
                  next_q.jtag = 1'b1;
               end else if (flash_protected_in) begin
                  next_q.mode    = rbm_pkg::RBM_USER;
                  next_q.refused = 1'b1;
               end else begin
                  next_q.mode  = rbm_pkg::RBM_DEBUG;
                  next_q.jtag  = 1'b1;
                  next_q.debug = 1'b1;
               end
            end
         end
         rbm_pkg::RBM_ST_RUN: begin
            if (restart) begin
               // new power-on or hardware reset resamples straps
               next_q.fsm   = rbm_pkg::RBM_ST_SETTLE;
               next_q.cnt   = CNT_LOAD;
               next_q.valid = 1'b0;
            end
         end
         default: begin
            next_q = RST;
         end
      endcase
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         q <= RST;
      end else begin
         q <= next_q;
      end
   end

   assign mode_out           = q.mode;
   assign mode_valid_out     = q.valid;
   assign pc_start_out       = q.pc;
   assign osc_pll_bypass_out = q.bypass;
   assign jtag_enable_out    = q.jtag;
   assign debug_enable_out   = q.debug;
   assign debug_refused_out  = q.refused;
   assign boot_invalid_out   = q.invalid;
   assign regulator_on_out   = q.reg_on;

   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!resetn_in);

   a_decide_on_capture: assert property (
      $rose(q.valid) |-> $past(capture))
      else $error("mode became valid without capture");
   a_user_mode: assert property (
      capture && q.stable.boot_control && !q.stable.test_select
      |=> q.valid && q.mode == rbm_pkg::RBM_USER && !q.jtag)
      else $error("user mode not selected");
   a_bootstrap_mode: assert property (
      capture && !q.stable.boot_control && !q.stable.test_select
      |=> q.valid && q.mode == rbm_pkg::RBM_BOOTSTRAP && !q.debug)
      else $error("bootstrap loader mode not selected");
   a_debug_mode: assert property (
      capture && q.stable == 3'b010 && !flash_protected_in
      |=> q.mode == rbm_pkg::RBM_DEBUG && q.debug && !q.refused)
      else $error("debug mode not selected");
   a_debug_refuse: assert property (
      capture && q.stable == 3'b010 && flash_protected_in
      |=> !q.debug && q.refused && q.mode == rbm_pkg::RBM_USER)
      else $error("debug mode not refused under protection");
   a_jtag_mode: assert property (
      capture && q.stable == 3'b110
      |=> q.mode == rbm_pkg::RBM_USER_JTAG && q.jtag && !q.debug)
      else $error("user jtag mode not selected");
   a_pc_start: assert property (
      q.valid |-> q.pc == `RBM_PC_START && !q.bypass)
      else $error("start address or bypass wrong");
   a_wake_regulator: assert property (
      wakeup_req_in |=> q.reg_on)
      else $error("wake-up did not switch regulator on");
   a_regulator_hold: assert property (
      !wakeup_req_in && !regulator_off_req_in |=> $stable(q.reg_on))
      else $error("regulator changed without cause");
   a_mode_hold: assert property (
      q.valid && !restart |=> q.valid && $stable(q.mode)
      && $stable(q.jtag) && $stable(q.debug))
      else $error("mode changed without a reset");
   a_resample: assert property (
      restart |=> !q.valid [*3])
      else $error("reset did not restart sampling");
   a_regulator_off: assert property (
      regulator_off_req_in && !wakeup_req_in |=> !q.reg_on)
      else $error("regulator off request ignored");
   a_invalid_combo: assert property (
      capture && q.stable.test_select && q.stable.port0_bit0
      |=> q.invalid && q.mode == rbm_pkg::RBM_USER && !q.jtag)
      else $error("unlisted strap combination not flagged");
   a_debug_jtag: assert property (
      q.debug |-> q.jtag && q.mode == rbm_pkg::RBM_DEBUG)
      else $error("debug mode without jtag access");
   a_refuse_no_debug: assert property (
      q.refused |-> !q.debug && !q.jtag)
      else $error("refused debug still enabled");

   c_user: cover property ($rose(q.valid) && q.mode == rbm_pkg::RBM_USER);
   c_boot: cover property (
      $rose(q.valid) && q.mode == rbm_pkg::RBM_BOOTSTRAP);
   c_debug: cover property ($rose(q.valid) && q.debug);
   c_jtag: cover property (
      $rose(q.valid) && q.mode == rbm_pkg::RBM_USER_JTAG);
   c_wake: cover property (!q.reg_on ##1 wakeup_req_in ##1 q.reg_on);
endmodule

/* verification/rbm_strap_model.sv */
// board strap model driving the three boot pins
`timescale 1ns/1ps
module rbm_strap_model (
   input  wire logic [2:0] level_in,
   output logic            boot_control_out,
   output logic            test_select_out,
   output logic            port0_bit0_out
);
   // straps held steady through reset and settle
   assign boot_control_out = level_in[2];
   assign test_select_out  = level_in[1];
   assign port0_bit0_out   = level_in[0];
endmodule

/* verification/reset_boot_mode_select_bench.sv */
// bench for the reset boot mode selector
`timescale 1ns/1ps
module reset_boot_mode_select_bench;
   localparam int S = 5;
   logic               clk_in, resetn_in, por, hw, wake, off, prot;
   logic               bc, ts, p0, valid, jtag, dbg, refd, inval, reg_on;
   logic               bypass, valid_q;
   logic [2:0]         lvl;
   logic [15:0]        pc;
   logic [7:0]         lfsr;
   logic [5:0]         exp_q[$];
   rbm_pkg::rbm_mode_t mode;
   int                 err_total, compares, n;

   rbm_strap_model u_strap (.level_in(lvl), .boot_control_out(bc),
      .test_select_out(ts), .port0_bit0_out(p0));
   rbm_boot_select #(.SETTLE_CYCLES(S)) DUT (.clk_in(clk_in),
      .resetn_in(resetn_in), .boot_control_pin_in(bc),
      .test_select_pin_in(ts), .port0_bit0_pin_in(p0), .por_req_in(por),
      .hw_reset_req_in(hw), .wakeup_req_in(wake),
      .regulator_off_req_in(off), .flash_protected_in(prot),
      .mode_out(mode), .mode_valid_out(valid), .pc_start_out(pc),
      .osc_pll_bypass_out(bypass), .jtag_enable_out(jtag),
      .debug_enable_out(dbg), .debug_refused_out(refd),
      .boot_invalid_out(inval), .regulator_on_out(reg_on));

   initial clk_in = 1'b0;
   always #2.5 clk_in = ~clk_in;

   function automatic logic [5:0] expect_of(logic [2:0] l, logic p);
      logic [1:0] m;
      logic       rf;
      rf = 1'b0;
      if (l[1] == 1'b0) begin
         m = l[2] ? 2'b00 : 2'b01;
      end else if (l[0] == 1'b1) begin
         m = 2'b00;
      end else begin
         m = l[2] ? 2'b11 : (p ? 2'b00 : 2'b10);
         rf = ~l[2] & p;
      end
      return {m, m[1], m == 2'b10, rf, l[1] & l[0]};
   endfunction

   task automatic check(logic [16:0] g, logic [16:0] e, string msg);
      compares++;
      if (g !== e) begin
         err_total++;
         $display("Error at %0t: %s", $time, msg);
      end
   endtask

   task automatic tick;
      @(posedge clk_in);
      #1;
   endtask

   task automatic wait_valid;
      int i;
      i = 0;
      while (valid !== 1'b1 && i < 3 * S) begin
         tick;
         i++;
      end
      if (valid !== 1'b1) begin
         err_total++;
         $display("Error at %0t: no capture in time", $time);
      end
   endtask

   task automatic run_case(logic [2:0] l, logic p, logic use_por);
      lvl = l;
      prot = p;
      repeat (5) tick;
      exp_q.push_back(expect_of(l, p));
      if (use_por) por = 1'b1; else hw = 1'b1;
      tick;
      por = 1'b0;
      hw = 1'b0;
      wait_valid;
      lvl = ~l;
      off = 1'b1;
      tick;
      off = 1'b0;
      tick;
      check({16'h0, reg_on}, 17'h0, "regulator off");
      wake = 1'b1;
      tick;
      wake = 1'b0;
      repeat (S + 4) tick;
      check({16'h0, reg_on}, 17'h1, "wake regulator");
      check({mode, jtag, dbg, refd, inval}, expect_of(l, p), "held");
      $display("case %0d done", n);
      n++;
   endtask

   // capture monitor
   always @(negedge clk_in) begin
      if (valid === 1'b1 && valid_q !== 1'b1) begin
         if (exp_q.size() == 0) begin
            check(17'h1, 17'h0, "unexpected capture");
         end else begin
            check({mode, jtag, dbg, refd, inval}, exp_q.pop_front(),
               "mode");
            check({pc, bypass}, 17'h0, "pc bypass");
         end
      end
      valid_q = valid;
   end

   task automatic final_report;
      $display("compares %0d errors %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   initial begin
      {resetn_in, por, hw, wake, off, prot} = 6'h0;
      lvl = 3'b100;
      lfsr = 8'h49;
      exp_q.push_back(expect_of(3'b100, 1'b0));
      repeat (2) tick;
      check({valid, reg_on, 15'h0}, 17'h8000, "reset values");
      resetn_in = 1'b1;
      wait_valid;
      for (int i = 0; i < 16; i++) begin
         run_case(i[2:0], i[3], i[0]);
      end
      repeat (6) begin
         lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
         run_case(lfsr[2:0], lfsr[3], lfsr[4]);
      end
      check(17'(exp_q.size()), 17'h0, "missing capture");
      final_report;
   end

   initial begin
      #20000;
      err_total++;
      $display("Error at %0t: watchdog expired", $time);
      final_report;
   end
endmodule
